// ==== rtl/pcc_pfd.sv ====
// phase detector with anti-backlash window and pump mode override
// assumes both counter outputs are synchronous to clk_i
`timescale 1ns/1ps
module pcc_pfd (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // counter outputs
   input  wire logic       ref_i,
   input  wire logic       fb_i,
   // active configuration
   input  wire logic       en_i,
   input  wire logic       swap_i,
   input  wire logic [2:0] mode_i,
   input  wire logic [1:0] abw_i,
   // pump commands
   output logic            up_o,
   output logic            dn_o,
   output logic            oe_o
);
   import pcc_pkg::*;
   logic       ref_p_q, fb_p_q, up_q, dn_q;
   logic [1:0] abw_cnt_q;
   wire        both_w = up_q & dn_q;
   wire        clr_w  = both_w && (abw_cnt_q == abw_i);
   wire        nup_w  = swap_i ? dn_q : up_q;
   wire        ndn_w  = swap_i ? up_q : dn_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_p_q   <= 1'b0;
         fb_p_q    <= 1'b0;
         up_q      <= 1'b0;
         dn_q      <= 1'b0;
         abw_cnt_q <= 2'h0;
         up_o      <= 1'b0;
         dn_o      <= 1'b0;
         oe_o      <= 1'b0;
      end else begin
         ref_p_q   <= ref_i;
         fb_p_q    <= fb_i;
         // both high: hold for abw+1 cycles, then release together
         up_q      <= en_i && !clr_w && (up_q | (ref_i & ~ref_p_q));
         dn_q      <= en_i && !clr_w && (dn_q | (fb_i & ~fb_p_q));
         abw_cnt_q <= both_w && !clr_w ? 2'(abw_cnt_q + 2'h1) : 2'h0;
         case (mode_i)
            CP_NORMAL: begin
               up_o <= en_i & nup_w;
               dn_o <= en_i & ndn_w;
               oe_o <= en_i;
            end
            CP_UP: begin
               up_o <= en_i;
               dn_o <= 1'b0;
               oe_o <= en_i;
            end
            CP_DOWN: begin
               up_o <= 1'b0;
               dn_o <= en_i;
               oe_o <= en_i;
            end
            default: begin
               up_o <= 1'b0;
               dn_o <= 1'b0;
               oe_o <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ==== rtl/pcc_pkg.sv ====
// constants and types for the loop and source configuration block
// assumes an AXI4-Lite master and a single 20 MHz clock
package pcc_pkg;
   localparam int          ADDR_W      = 12;
   localparam int          IDX_W       = 10;
   // register indices, byte address is four times the index
   localparam logic [9:0]  IDX_LOOP    = 10'h010;
   localparam logic [9:0]  IDX_ABW     = 10'h017;
   localparam logic [9:0]  IDX_CAL     = 10'h018;
   localparam logic [9:0]  IDX_PDIV    = 10'h1E0;
   localparam logic [9:0]  IDX_SRC     = 10'h1E1;
   localparam logic [9:0]  IDX_STAT    = 10'h1F0;
   localparam logic [9:0]  IDX_UPD     = 10'h232;
   // field positions
   localparam int          PWR_LSB     = 0;
   localparam int          MODE_LSB    = 4;
   localparam int          POL_BIT     = 7;
   localparam int          ABW_LSB     = 0;
   localparam int          CUR_LSB     = 4;
   localparam int          CAL_BIT     = 0;
   localparam int          PDIV_LSB    = 0;
   localparam int          BYP_BIT     = 0;
   localparam int          SEL_BIT     = 1;
   localparam int          UPD_BIT     = 0;
   // reset values
   localparam logic [7:0]  RST_LOOP    = 8'h01;
   localparam logic [7:0]  RST_ABW     = 8'h00;
   localparam logic [7:0]  RST_CAL     = 8'h00;
   localparam logic [7:0]  RST_PDIV    = 8'h02;
   localparam logic [7:0]  RST_SRC     = 8'h00;
   localparam logic [7:0]  RST_UPD     = 8'h00;
   // field encodings
   localparam logic [1:0]  PWR_ON      = 2'h0;
   localparam logic [1:0]  PWR_DOWN    = 2'h1;
   localparam logic [2:0]  CP_HIZ      = 3'h0;
   localparam logic [2:0]  CP_UP       = 3'h1;
   localparam logic [2:0]  CP_DOWN     = 3'h2;
   localparam logic [2:0]  CP_NORMAL   = 3'h3;
   // timing count
   localparam int          CAL_CYCLES  = 64;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] loop;
      logic [7:0] abw;
      logic [7:0] cal;
      logic [7:0] pdiv;
      logic [7:0] src;
   } pcc_cfg_s;
endpackage

// ==== rtl/pcc_post_div.sv ====
// source selection, post-divider and bypass for the distribution clock
// assumes clock pins are far slower than clk_i and arrive asynchronously
`timescale 1ns/1ps
module pcc_post_div (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // source pins, bit 0 external input, bit 1 internal oscillator
   input  wire logic [1:0] src_pins_i,
   // active configuration
   input  wire logic       sel_int_i,
   input  wire logic       bypass_i,
   input  wire logic [2:0] ratio_i,
   // distribution clock
   output logic            dist_clk_o
);
   import pcc_pkg::*;
   logic [1:0] s1_q, s2_q;
   logic       src_q, div_q;
   logic [2:0] cnt_q;
   wire        src_w  = sel_int_i ? s2_q[1] : s2_q[0];
   wire        edge_w = src_w & ~src_q;
   // 000 -> 2 ... 100 -> 6, codes above saturate at 6
   wire  [2:0] n_w    = (ratio_i > 3'h4) ? 3'h6 : 3'(ratio_i + 3'h2);
   wire  [2:0] nxt_w  = (cnt_q >= 3'(n_w - 3'h1)) ? 3'h0 : 3'(cnt_q + 3'h1);
   wire        hi_w   = nxt_w < (n_w >> 1);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q       <= 2'h0;
         s2_q       <= 2'h0;
         src_q      <= 1'b0;
         cnt_q      <= 3'h0;
         div_q      <= 1'b0;
         dist_clk_o <= 1'b0;
      end else begin
         s1_q       <= src_pins_i;
         s2_q       <= s1_q;
         src_q      <= src_w;
         if (edge_w) begin
            cnt_q <= nxt_w;
            div_q <= hi_w;
         end
         dist_clk_o <= bypass_i ? src_q : div_q;
      end
   end
endmodule

// ==== rtl/pcc_top.sv ====
// loop power, pump and distribution source configuration with an
// AXI4-Lite register file, buffered values and a single apply strobe
// assumes one 20 MHz clock; clock pins are asynchronous to it
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pcc_top #(
   parameter int CAL_LEN = pcc_pkg::CAL_CYCLES
) (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   // AXI4-Lite write address and data
   input  wire logic [pcc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read
   input  wire logic [pcc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // clock pins and counter outputs
   input  wire logic                      ext_clk_i,
   input  wire logic                      osc_clk_i,
   input  wire logic                      ref_div_i,
   input  wire logic                      fb_div_i,
   // loop and distribution controls
   output logic                           pll_pd_o,
   output logic                           cal_busy_o,
   output logic                           dist_clk_o,
   output logic                           pump_up_o,
   output logic                           pump_dn_o,
   output logic                           pump_oe_o,
   output logic [2:0]                     pump_cur_o
);
   import pcc_pkg::*;

   pcc_cfg_s              shd_q, act_q;
   logic [7:0]            upd_q;
   logic                  aw_full_q, w_full_q;
   logic [IDX_W-1:0]      aw_idx_q;
   logic [31:0]           wdata_q;
   logic                  wstrb0_q;
   logic [15:0]           cal_cnt_q;
   logic                  applied_q;

   // write decode, performed once both halves are held
   wire        wr_go_w  = aw_full_q && w_full_q && !s_axi_bvalid;
   wire [7:0]  wb_w     = wdata_q[7:0];
   wire        wr_en_w  = wr_go_w && wstrb0_q;
   wire        hit_loop = aw_idx_q == IDX_LOOP;
   wire        hit_abw  = aw_idx_q == IDX_ABW;
   wire        hit_cal  = aw_idx_q == IDX_CAL;
   wire        hit_pdiv = aw_idx_q == IDX_PDIV;
   wire        hit_src  = aw_idx_q == IDX_SRC;
   wire        hit_upd  = aw_idx_q == IDX_UPD;
   wire        wr_map_w = hit_loop | hit_abw | hit_cal | hit_pdiv
                        | hit_src | hit_upd;
   wire        apply_w  = wr_en_w && hit_upd && wb_w[UPD_BIT];
   // a calibration starts only on a 0 -> 1 move of the applied bit
   wire        cal_go_w = apply_w && shd_q.cal[CAL_BIT]
                        && !act_q.cal[CAL_BIT];

   // read decode
   wire [IDX_W-1:0] ar_idx_w = s_axi_araddr[ADDR_W-1:2];
   wire [7:0]  stat_w   = {5'h0, act_q.src[SEL_BIT],
                           !pll_pd_o, cal_busy_o};
   logic [7:0] rd_byte_w;
   logic       rd_map_w;
   always_comb begin
      rd_map_w  = 1'b1;
      case (ar_idx_w)
         IDX_LOOP: rd_byte_w = shd_q.loop;
         IDX_ABW:  rd_byte_w = shd_q.abw;
         IDX_CAL:  rd_byte_w = shd_q.cal;
         IDX_PDIV: rd_byte_w = shd_q.pdiv;
         IDX_SRC:  rd_byte_w = shd_q.src;
         IDX_UPD:  rd_byte_w = upd_q;
         IDX_STAT: rd_byte_w = stat_w;
         default: begin
            rd_byte_w = 8'h00;
            rd_map_w  = 1'b0;
         end
      endcase
   end

   // write address and data channels, taken in either order
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         aw_idx_q      <= '0;
         wdata_q       <= 32'h0000_0000;
         wstrb0_q      <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q     <= 1'b1;
            aw_idx_q      <= s_axi_awaddr[ADDR_W-1:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb0_q     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_go_w) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map_w ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // read channel, one cycle from address to data
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_byte_w};
         s_axi_rresp   <= rd_map_w ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // buffered registers, written by software only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shd_q <= '{RST_LOOP, RST_ABW, RST_CAL, RST_PDIV, RST_SRC};
         upd_q <= RST_UPD;
      end else if (wr_en_w) begin
         if (hit_loop) shd_q.loop <= wb_w;
         if (hit_abw)  shd_q.abw  <= wb_w;
         if (hit_cal)  shd_q.cal  <= wb_w;
         if (hit_pdiv) shd_q.pdiv <= wb_w;
         if (hit_src)  shd_q.src  <= wb_w;
         // apply bit is never stored, so it reads back as zero
         if (hit_upd)  upd_q <= wb_w & ~8'h01;
      end
   end

   // active registers move as one word on the apply strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_q     <= '{RST_LOOP, RST_ABW, RST_CAL, RST_PDIV, RST_SRC};
         pll_pd_o  <= 1'b1;
         applied_q <= 1'b0;
      end else if (apply_w) begin
         act_q     <= shd_q;
         pll_pd_o  <= shd_q.loop[PWR_LSB+:2] != PWR_ON;
         applied_q <= 1'b1;
      end
   end

   // oscillator calibration timer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cal_cnt_q  <= 16'h0000;
         cal_busy_o <= 1'b0;
      end else if (cal_go_w) begin
         cal_cnt_q  <= 16'(CAL_LEN - 1);
         cal_busy_o <= 1'b1;
      end else if (cal_cnt_q != 16'h0000) begin
         cal_cnt_q  <= 16'(cal_cnt_q - 16'h0001);
      end else begin
         cal_busy_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) pump_cur_o <= 3'h0;
      else          pump_cur_o <= act_q.abw[CUR_LSB+:3];
   end

   pcc_post_div u_post_div (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .src_pins_i ({osc_clk_i, ext_clk_i}),
      .sel_int_i  (act_q.src[SEL_BIT]),
      .bypass_i   (act_q.src[BYP_BIT]),
      .ratio_i    (act_q.pdiv[PDIV_LSB+:3]),
      .dist_clk_o (dist_clk_o)
   );

   // polarity only swaps pump sense with an external oscillator
   wire swap_w = act_q.loop[POL_BIT] && !act_q.src[SEL_BIT];

   pcc_pfd u_pfd (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .ref_i   (ref_div_i),
      .fb_i    (fb_div_i),
      .en_i    (!pll_pd_o),
      .swap_i  (swap_w),
      .mode_i  (act_q.loop[MODE_LSB+:3]),
      .abw_i   (act_q.abw[ABW_LSB+:2]),
      .up_o    (pump_up_o),
      .dn_o    (pump_dn_o),
      .oe_o    (pump_oe_o)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_apply_copies;
      apply_w |=> act_q == $past(shd_q);
   endproperty
   a_apply_copies: assert property (p_apply_copies)
      else $error("active set differs from buffer after apply");

   property p_no_apply_holds;
      !apply_w |=> $stable(act_q) && $stable(pll_pd_o);
   endproperty
   a_no_apply_holds: assert property (p_no_apply_holds)
      else $error("active set moved without apply");

   property p_pwr_down;
      apply_w && shd_q.loop[PWR_LSB+:2] == PWR_DOWN |=> pll_pd_o;
   endproperty
   a_pwr_down: assert property (p_pwr_down)
      else $error("loop not powered down by field 01");

   property p_pwr_on;
      apply_w && shd_q.loop[PWR_LSB+:2] == PWR_ON |=> !pll_pd_o;
   endproperty
   a_pwr_on: assert property (p_pwr_on)
      else $error("loop not running with field 00");

   sequence s_cal_go;
      cal_go_w;
   endsequence
   property p_cal_start;
      s_cal_go |=> cal_busy_o [*2];
   endproperty
   a_cal_start: assert property (p_cal_start)
      else $error("calibration did not start");

   property p_cal_needs_edge;
      apply_w && act_q.cal[CAL_BIT] && !cal_busy_o |=> !cal_busy_o;
   endproperty
   a_cal_needs_edge: assert property (p_cal_needs_edge)
      else $error("calibration restarted without clearing bit");

   property p_hiz;
      (act_q.loop[MODE_LSB+:3] == CP_HIZ) [*2] |-> !pump_oe_o;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("pump driven in hold mode");

   property p_force_up;
      (act_q.loop[MODE_LSB+:3] == CP_UP && !pll_pd_o) [*2]
         |-> pump_up_o && !pump_dn_o && pump_oe_o;
   endproperty
   a_force_up: assert property (p_force_up)
      else $error("forced pump up not driven");

   property p_reset_defaults;
      !applied_q |-> pll_pd_o && act_q.pdiv == RST_PDIV
                     && act_q.src == RST_SRC;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("defaults lost before first apply");

   property p_unmapped_err;
      wr_go_w && !wr_map_w |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped write not answered with an error");

   property p_shadow_write;
      wr_en_w && hit_loop |=> shd_q.loop == $past(wb_w);
   endproperty
   a_shadow_write: assert property (p_shadow_write)
      else $error("buffered loop register not written");

   property p_apply_reads_zero;
      s_axi_arvalid && s_axi_arready && ar_idx_w == IDX_UPD
         |=> !s_axi_rdata[UPD_BIT];
   endproperty
   a_apply_reads_zero: assert property (p_apply_reads_zero)
      else $error("apply bit did not read back as zero");

   property p_pump_cur;
      apply_w |=> ##1 pump_cur_o == $past(shd_q.abw[CUR_LSB+:3], 2);
   endproperty
   a_pump_cur: assert property (p_pump_cur)
      else $error("pump current step not taken from active set");

   property p_cal_ends;
      cal_busy_o && cal_cnt_q == 16'h0000 && !cal_go_w |=> !cal_busy_o;
   endproperty
   a_cal_ends: assert property (p_cal_ends)
      else $error("calibration outlasted its timer");
endmodule

// ==== verification/pll_source_config_control_test.sv ====
// self-checking bench for the loop and source configuration block
// assumes pcc_pkg and the rtl files are compiled first; one 20 MHz clock
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); \
   end end
module pll_source_config_control_test;
   import pcc_pkg::*;
   localparam int CAL_LEN = 4;
   localparam int WIN     = 240;
   logic              clk_i   = 1'b0;
   logic              rst_n_i = 1'b0;
   logic [ADDR_W-1:0] awaddr  = '0;
   logic [ADDR_W-1:0] araddr  = '0;
   logic              awvalid = 1'b0;
   logic              wvalid  = 1'b0;
   logic              arvalid = 1'b0;
   logic              bready  = 1'b0;
   logic              rready  = 1'b0;
   logic [31:0]       wdata   = '0;
   logic [3:0]        wstrb   = '0;
   logic              ref_div = 1'b0;
   logic              fb_div  = 1'b0;
   logic              awready, wready, arready, bvalid, rvalid;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   logic              pll_pd, cal_busy, dist_clk, up, dn, oe;
   logic [2:0]        pump_cur;
   logic [1:0]        last_resp;
   logic [31:0]       last_rdata;
   int                cyc = 0;
   int                num_errors = 0;
   int                compares = 0;
   wire               ext_clk = ((cyc / 3) % 2) == 1;
   wire               osc_clk = ((cyc / 5) % 2) == 1;

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;

   pcc_top #(.CAL_LEN(CAL_LEN)) pcc_top_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_clk_i(ext_clk), .osc_clk_i(osc_clk), .ref_div_i(ref_div),
      .fb_div_i(fb_div), .pll_pd_o(pll_pd), .cal_busy_o(cal_busy),
      .dist_clk_o(dist_clk), .pump_up_o(up), .pump_dn_o(dn),
      .pump_oe_o(oe), .pump_cur_o(pump_cur)
   );

   task automatic complete_run;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   function automatic logic [ADDR_W-1:0] ba(input logic [9:0] i);
      return {i, 2'b00};
   endfunction

   // address and data offered together, each dropped when taken
   task automatic wr(input logic [9:0] i, input logic [7:0] d,
                     input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      @(posedge clk_i);
      awaddr  <= ba(i);
      wdata   <= {24'h0, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      last_resp = bresp;
      bready <= 1'b0;
      if (n >= 100) begin
         num_errors++;
         complete_run();
      end
   endtask

   task automatic rd(input logic [9:0] i);
      int n;
      n = 0;
      @(posedge clk_i);
      araddr  <= ba(i);
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      last_resp  = rresp;
      last_rdata = rdata;
      rready <= 1'b0;
      if (n >= 100) begin
         num_errors++;
         complete_run();
      end
   endtask

   task automatic apply;
      wr(IDX_UPD, 8'h01);
   endtask

   task automatic pulse(input bit r);
      @(posedge clk_i);
      if (r) ref_div <= 1'b1;
      else fb_div <= 1'b1;
      @(posedge clk_i);
      ref_div <= 1'b0;
      fb_div  <= 1'b0;
      tick(3);
   endtask

   // rising edges of the distribution clock over a fixed window
   function automatic int exp_edges(input bit sel, input bit byp,
                                    input logic [2:0] code);
      int per;
      int dv;
      per = sel ? 10 : 6;
      dv  = byp ? 1 : ((code > 3'h4) ? 6 : int'(code) + 2);
      return WIN / (per * dv);
   endfunction

   task automatic check_dist(input bit sel, input bit byp,
                             input logic [2:0] code);
      int   n;
      int   e;
      logic prev;
      wr(IDX_PDIV, {5'h0, code});
      wr(IDX_SRC, {6'h0, sel, byp});
      apply();
      tick(30);
      n    = 0;
      e    = exp_edges(sel, byp, code);
      prev = dist_clk;
      repeat (WIN) begin
         @(posedge clk_i);
         if (dist_clk === 1'b1 && prev === 1'b0) n++;
         prev = dist_clk;
      end
      `CHK((n >= e - 1) && (n <= e + 1), 1'b1)
   endtask

   logic [9:0] idx_tab [5] = '{IDX_LOOP, IDX_ABW, IDX_CAL, IDX_PDIV, IDX_SRC};
   logic [7:0] rst_tab [5] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00};
   logic [7:0] d;
   logic [2:0] cur;
   int         k;

   initial begin
      void'($urandom(32'hEC004700));
      tick(16);
      rst_n_i <= 1'b1;
      `CHK(pll_pd, 1'b1)
      for (int i = 0; i < 5; i++) begin
         rd(idx_tab[i]);
         `CHK(last_rdata, {24'h0, rst_tab[i]})
      end
      for (int i = 0; i < 8; i++) begin
         k = $urandom_range(4, 1);
         d = 8'($urandom);
         if (k == 4 && d[SEL_BIT]) d[BYP_BIT] = 1'b0;
         wr(idx_tab[k], d);
         rd(idx_tab[k]);
         `CHK(last_rdata, {24'h0, d})
      end
      wr(IDX_ABW, 8'h2A);
      wr(IDX_ABW, 8'h55, 4'h0);
      rd(IDX_ABW);
      `CHK(last_rdata[7:0], 8'h2A)
      wr(10'h040, 8'hFF);
      `CHK(last_resp, RESP_SLVERR)
      rd(10'h040);
      `CHK({last_resp, last_rdata}, {RESP_SLVERR, 32'h0})
      // calibration only on a fresh 0 to 1 of the applied bit
      wr(IDX_CAL, 8'h00);
      apply();
      tick(CAL_LEN + 4);
      wr(IDX_CAL, 8'h01);
      apply();
      `CHK(cal_busy, 1'b1)
      tick(CAL_LEN + 2);
      `CHK(cal_busy, 1'b0)
      apply();
      tick(1);
      `CHK(cal_busy, 1'b0)
      wr(IDX_CAL, 8'h00);
      apply();
      wr(IDX_CAL, 8'h01);
      apply();
      `CHK(cal_busy, 1'b1)
      // power field is buffered until the strobe
      wr(IDX_LOOP, 8'h30);
      tick(3);
      `CHK(pll_pd, 1'b1)
      rd(IDX_UPD);
      `CHK(last_rdata[0], 1'b0)
      apply();
      tick(2);
      `CHK(pll_pd, 1'b0)
      rd(IDX_STAT);
      `CHK(last_rdata[1], 1'b1)
      for (int p = 1; p < 4; p++) begin
         wr(IDX_LOOP, {6'h0C, 2'(p)});
         apply();
         tick(2);
         `CHK(pll_pd, 1'b1)
      end
      cur = 3'($urandom);
      wr(IDX_ABW, {1'b0, cur, 4'h1});
      wr(IDX_SRC, 8'h00);
      wr(IDX_LOOP, 8'h30);
      apply();
      tick(2);
      `CHK(pump_cur, cur)
      pulse(1'b1);
      `CHK({up, dn, oe}, 3'b101)
      pulse(1'b0);
      tick(6);
      `CHK({up, dn}, 2'b00)
      wr(IDX_LOOP, 8'hB0);
      apply();
      pulse(1'b1);
      `CHK({up, dn}, 2'b01)
      pulse(1'b0);
      tick(6);
      wr(IDX_SRC, 8'h02);
      apply();
      pulse(1'b1);
      `CHK({up, dn}, 2'b10)
      pulse(1'b0);
      tick(6);
      for (int m = 0; m < 8; m++) begin
         wr(IDX_LOOP, {1'b0, 3'(m), 4'h0});
         apply();
         tick(3);
         `CHK({up, dn, oe}, {m == 1, m == 2, m >= 1 && m <= 3})
      end
      for (int c = 0; c < 8; c++) begin
         check_dist(1'b0, 1'b0, 3'(c));
      end
      check_dist(1'b0, 1'b1, 3'h2);
      check_dist(1'b1, 1'b0, 3'h4);
      check_dist(1'b1, 1'b0, 3'h0);
      complete_run();
   end
endmodule
